// ===== dv/host_model.sv
// terminal-side model: takes reply bytes from the interpreter
// assumes a valid/ready reply stream; slow makes it stall
`timescale 1ns/1ps
module host_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic slow,
  output logic      tx_ready
);
  logic [1:0] div_r;
  // phase counter, moved off the sampling edge
  always_ff @(negedge clk or posedge reset) begin
    if (reset) div_r <= 2'h0;
    else div_r <= div_r + 2'h1;
  end
  // prompt, or ready one cycle in four
  assign tx_ready = !slow || div_r == 2'h0;
endmodule

// ===== dv/sci_sva.sv
// port checker for the serial command interpreter
// assumes it is bound onto serial_command_interpreter, one clock
`timescale 1ns/1ps
module sci_sva (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            cmd_enable,
  input wire sci_pkg::tmode_t nv_test_mode,
  input wire logic            rx_abort,
  input wire logic            radio_valid,
  input wire logic [7:0]      radio_data,
  input wire logic            radio_ready,
  input wire logic            tx_valid,
  input wire logic [7:0]      tx_byte,
  input wire logic            tx_ready,
  input wire sci_pkg::tmode_t test_mode,
  input wire logic            save_req,
  input wire sci_pkg::tmode_t save_data
);
  import sci_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // pulses and held streams
  abort_pulse_a: assert property (rx_abort |=> !rx_abort)
    else $error("abort pulse longer than one cycle");
  save_pulse_a: assert property (save_req |=> !save_req)
    else $error("save pulse longer than one cycle");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte)) else $error("reply byte dropped");
  radio_hold_a: assert property (radio_valid && !radio_ready |=>
    radio_valid && $stable(radio_data)) else $error("radio byte dropped");
  // feature off: no command side effects
  off_quiet_a: assert property (!cmd_enable && !tx_valid |=>
    !tx_valid) else $error("reply while commands off");
  off_no_act_a: assert property (!cmd_enable |->
    !save_req && !rx_abort) else $error("command action while off");
  // stored value and power-up restore
  save_value_a: assert property (save_req |->
    save_data == test_mode) else $error("saved value not current");
  nv_restore_a: assert property ($fell(reset) |->
    ##[1:2] test_mode == nv_test_mode) else $error("no restore");
  cover property (save_req);
  cover property (rx_abort);
  cover property (tx_valid && tx_ready && tx_byte == 8'h03);
endmodule

bind serial_command_interpreter sci_sva chk (
  .clk(clk), .reset(reset), .cmd_enable(cmd_enable),
  .nv_test_mode(nv_test_mode), .rx_abort(rx_abort),
  .radio_valid(radio_valid), .radio_data(radio_data),
  .radio_ready(radio_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .test_mode(test_mode), .save_req(save_req),
  .save_data(save_data));

// ===== dv/serial_command_interpreter_tb.sv
// bench of the command interpreter: host stimulus, radio sink
// assumes design, fifo, host model and checker compiled before it
`timescale 1ns/1ps
`include "sci_consts.svh"
module serial_command_interpreter_tb;
  import sci_pkg::*;
  logic        clk, reset, cmd_enable, ext_syntax, rx_start, rx_valid;
  logic        rx_ready, radio_busy, rx_abort, radio_valid, ok;
  logic        tx_valid, tx_ready, save_req, slow, rhold;
  logic        radio_ready = 1'b0;
  logic [7:0]  rx_byte, radio_data, tx_byte;
  logic [15:0] char_cycles;
  logic [31:0] seed;
  tmode_t      nv_test_mode, test_mode, save_data, saved;
  logic [7:0]  hq[$], rq[$], eq[$];
  int          err_count = 0, n_checks = 0, n_abort = 0, n_save = 0;

  serial_command_interpreter dut (.clk(clk), .reset(reset),
    .cmd_enable(cmd_enable), .ext_syntax(ext_syntax),
    .char_cycles(char_cycles), .rx_start(rx_start), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .radio_busy(radio_busy),
    .rx_abort(rx_abort), .radio_valid(radio_valid),
    .radio_data(radio_data), .radio_ready(radio_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .nv_test_mode(nv_test_mode), .test_mode(test_mode),
    .save_req(save_req), .save_data(save_data));
  host_model host (.clk(clk), .reset(reset), .slow(slow),
    .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // radio side stalls at random unless held
  always @(negedge clk) radio_ready <= !rhold && rnd() > 32'h7fffffff;
  // capture both output streams and the pulses
  always @(posedge clk) begin
    if (tx_valid && tx_ready) hq.push_back(tx_byte);
    if (radio_valid && radio_ready) rq.push_back(radio_data);
    if (rx_abort) n_abort++;
    if (save_req) begin
      n_save++;
      saved = save_data;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected reply frame around the text
  function automatic void mk(input string t, ref logic [7:0] e[$]);
    e = {`SCI_CH_STX, `SCI_CH_S, `SCI_CH_L};
    foreach (t[i]) e.push_back(t[i]);
    e.push_back(`SCI_CH_ETX);
    e.push_back(`SCI_CH_CR);
    e.push_back(`SCI_CH_LF);
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // offer a byte, start pulse only for a fresh one; held if refused
  task automatic offer(input logic [7:0] b, input int lim);
    ok = 1'b0;
    @(negedge clk);
    rx_start = !rx_valid;
    rx_valid = 1'b1;
    rx_byte = b;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clk);
      ok = rx_ready;
      @(negedge clk);
      rx_start = 1'b0;
    end
    if (ok) rx_valid = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input logic f);
    offer(b, 40);
    chk(ok, 1'b1, "byte not taken");
    if (!ok) end_sim();
    if (f) eq.push_back(b);
  endtask
  // one string then the closing silence of four character times
  task automatic str(input string s, input logic f);
    foreach (s[i]) send(s[i], f);
    repeat (16) @(negedge clk);
  endtask
  task automatic reply(input string t, input logic none);
    logic [7:0] e[$];
    mk(t, e);
    if (none) e.delete();
    for (int i = 0; i < 400 && hq.size() < e.size(); i++) @(negedge clk);
    repeat (40) @(negedge clk);
    chk(hq.size(), e.size(), "reply length");
    if (hq.size() != e.size()) end_sim();
    foreach (e[i]) chk(hq[i], e[i], "reply byte");
    hq.delete();
    $display("reply test done: %s", t);
  endtask
  task automatic rchk();
    for (int i = 0; i < 400 && rq.size() < eq.size(); i++) @(negedge clk);
    chk(rq.size(), eq.size(), "radio length");
    if (rq.size() != eq.size()) end_sim();
    foreach (eq[i]) chk(rq[i], eq[i], "radio byte");
    rq.delete();
    eq.delete();
    $display("radio test done");
  endtask

  initial begin
    seed = 32'd27;
    {reset, cmd_enable, ext_syntax, slow, rhold} = 5'b11000;
    {rx_start, rx_valid, radio_busy} = 3'b000;
    rx_byte = 8'h00;
    char_cycles = 16'h0004;
    nv_test_mode = 2'h0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    // data passes, command replies and stays off the radio
    str("AB", 1'b1);
    str("SL%T?\015", 1'b0);
    reply("0", 1'b0);
    rchk();
    slow = 1'b1;
    str("SL%T=2\015\012", 1'b0);
    reply("OK", 1'b0);
    chk(test_mode, 2'h2, "test mode set");
    ext_syntax = 1'b1;
    str("SL%T?\015", 1'b0);
    reply("SL:2", 1'b0);
    {ext_syntax, slow} = 2'b00;
    str("SL%T=5\015", 1'b0);
    reply("ERROR", 1'b0);
    str("SLxy\015", 1'b0);
    reply("", 1'b1);
    str("SA", 1'b1);
    rchk();
    str("S", 1'b1);
    rchk();
    // a pause inside a command breaks it
    send("S", 1'b0);
    send("L", 1'b0);
    repeat (9) @(negedge clk);
    str("?\015", 1'b0);
    reply("", 1'b1);
    // save while a radio message is arriving
    radio_busy = 1'b1;
    str("SL**>\015", 1'b0);
    reply("OK", 1'b0);
    radio_busy = 1'b0;
    chk(n_abort, 1, "abort count");
    chk(n_save, 1, "save count");
    chk(saved, 2'h2, "saved value");
    // trailing character before the closing gap
    str("SL%T?\015Z", 1'b0);
    reply("", 1'b1);
    repeat (20) @(negedge clk);
    rq.delete();
    cmd_enable = 1'b0;
    str("SL%T?\015", 1'b1);
    reply("", 1'b1);
    rchk();
    cmd_enable = 1'b1;
    // random payload, then fill the buffer against a stalled radio
    for (int i = 0; i < 24; i++) send(8'h60 | 8'(rnd()) & 8'h1f, 1'b1);
    rchk();
    rhold = 1'b1;
    // output register, 16 fifo words and the input holding slot
    for (int i = 0; i < 18; i++) send(8'h61 + 8'(i), 1'b1);
    offer(8'h7a, 12);
    chk(ok, 1'b0, "full buffer took a byte");
    eq.push_back(8'h7a);
    rhold = 1'b0;
    send(8'h7a, 1'b0);
    rchk();
    // second reset restores the stored setting
    nv_test_mode = 2'h1;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    hq.delete();
    rq.delete();
    eq.delete();
    chk(test_mode, 2'h1, "restore after reset");
    str("SL%T?\015", 1'b0);
    reply("1", 1'b0);
    end_sim();
  end
endmodule

// ===== hdl/byte_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes depth is a power of two
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic reset,
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_r;
  logic [AW:0]      rp_nxt;
  logic             full;
  logic             empty;

  // full when pointers differ only in the wrap bit
  assign full     = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty    = (wp_r == rp_r);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp_r[AW-1:0]];

  // pointer advance
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (wr.valid && !full) wp_nxt = wp_r + 1'b1;
    if (rd.ready && !empty) rp_nxt = rp_r + 1'b1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (wr.valid && !full) mem[wp_r[AW-1:0]] <= wr.data;
  end
endmodule

// ===== hdl/serial_command_interpreter.sv
// in-band command interpreter on the modem's serial data port
// assumes an outside uart gives received bytes and start-bit pulses
// Function
// - commands are handled only when the stored command feature is on
// - command is one unbroken run, isolated by three character times silence
// - commands use the same character format and rate as data
// - a command arriving aborts an ongoing radio reception
// - command-made settings are volatile; power-up restores stored ones
// - a save command writes current settings into permanent storage
// - command is prefix letters, body, carriage return, optional line feed
// - carriage return alone terminates; line feed not required
// - every isolated prefixed string is a command; invalid bodies ignored
// - command characters never go to the radio
// - reply is stx, prefix letters, text, etx, cr, lf
// - reply text is OK, queried value, or ERROR
// - plain and extended syntax selectable, same command form
`timescale 1ns/1ps
`include "sci_consts.svh"
module serial_command_interpreter (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            cmd_enable,
  input  wire logic            ext_syntax,
  input  wire logic [15:0]     char_cycles,
  input  wire logic            rx_start,
  input  wire logic            rx_valid,
  input  wire logic [7:0]      rx_byte,
  output logic                 rx_ready,
  input  wire logic            radio_busy,
  output logic                 rx_abort,
  output logic                 radio_valid,
  output logic [7:0]           radio_data,
  input  wire logic            radio_ready,
  output logic                 tx_valid,
  output logic [7:0]           tx_byte,
  input  wire logic            tx_ready,
  input  wire sci_pkg::tmode_t nv_test_mode,
  output sci_pkg::tmode_t      test_mode,
  output logic                 save_req,
  output sci_pkg::tmode_t      save_data
);
  import sci_pkg::*;

  byte_stream_if #(.WIDTH(`SCI_FIFO_WIDTH)) fin ();
  byte_stream_if #(.WIDTH(`SCI_FIFO_WIDTH)) fout ();

  byte_fifo #(.WIDTH(`SCI_FIFO_WIDTH), .DEPTH(`SCI_FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .reset (reset),
    .wr    (fin.snk),
    .rd    (fout.src)
  );

  // silence counter in cycles since the last start bit or byte
  logic [17:0] quiet_r;
  logic [17:0] quiet_nxt;
  logic [17:0] gap_thr;
  logic [17:0] join_thr;
  logic        gap_hit;
  logic        take;

  assign take     = rx_valid && rx_ready;
  assign gap_thr  = 18'(`SCI_GAP_CHARS * char_cycles);
  assign join_thr = 18'(`SCI_JOIN_CHARS * char_cycles);
  assign gap_hit  = (quiet_r == gap_thr);

  always_comb begin
    quiet_nxt = quiet_r;
    if (rx_start || take) quiet_nxt = '0;
    else if (quiet_r != 18'h3ffff) quiet_nxt = quiet_r + 18'h00001;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) quiet_r <= 18'h3ffff;
    else quiet_r <= quiet_nxt;
  end

  // parser state
  parse_t     st_r;
  parse_t     st_nxt;
  parse_t     fl_next_r;
  parse_t     fl_next_nxt;
  logic [7:0] held_r;
  logic [7:0] held_nxt;
  logic       pend_r;
  logic       pend_nxt;
  logic [7:0] pbyte_r;
  logic [7:0] pbyte_nxt;
  logic       ready_r;
  logic       ready_nxt;
  logic       abort_r;
  logic       abort_nxt;
  logic [7:0] body_r [6];
  logic [7:0] body_nxt [6];
  logic [2:0] len_r;
  logic [2:0] len_nxt;
  logic       ovf_r;
  logic       ovf_nxt;
  logic       broken_r;
  logic       broken_nxt;
  logic       exec;

  // true when a terminator sits at position k and nothing but lf follows
  function automatic logic term_at(input logic [7:0] b [6],
                                   input logic [2:0] n,
                                   input logic [2:0] k);
    logic ok;
    ok = 1'b0;
    if (k < 3'h6 && b[k] == `SCI_CH_CR) begin
      if (n == k + 3'h1) ok = 1'b1;
      else if (n == k + 3'h2 && k < 3'h5 && b[k+3'h1] == `SCI_CH_LF)
        ok = 1'b1;
    end
    return ok;
  endfunction

  always_comb begin
    st_nxt      = st_r;
    fl_next_nxt = fl_next_r;
    held_nxt    = held_r;
    pend_nxt    = pend_r;
    pbyte_nxt   = pbyte_r;
    abort_nxt   = 1'b0;
    body_nxt    = body_r;
    len_nxt     = len_r;
    ovf_nxt     = ovf_r;
    broken_nxt  = broken_r;
    exec        = 1'b0;
    if (pend_r && fin.ready) pend_nxt = 1'b0;
    unique case (st_r)
      P_IDLE: begin
        if (take) begin
          if (cmd_enable && rx_byte == `SCI_CH_S) begin
            st_nxt = P_GOT_S;
          end else begin
            pend_nxt  = 1'b1;
            pbyte_nxt = rx_byte;
            st_nxt    = P_DATA;
          end
        end
      end
      P_DATA: begin
        if (take) begin
          pend_nxt  = 1'b1;
          pbyte_nxt = rx_byte;
        end else if (gap_hit) begin
          st_nxt = P_IDLE;
        end
      end
      P_GOT_S: begin
        if (take && rx_byte == `SCI_CH_L) begin
          st_nxt     = P_CMD;
          len_nxt    = '0;
          ovf_nxt    = 1'b0;
          broken_nxt = 1'b0;
          abort_nxt  = radio_busy;
        end else if (take) begin
          pend_nxt    = 1'b1;                            // not a command
          pbyte_nxt   = `SCI_CH_S;
          held_nxt    = rx_byte;
          fl_next_nxt = P_DATA;
          st_nxt      = P_FLUSH;
        end else if (gap_hit) begin
          held_nxt    = `SCI_CH_S;                       // lone letter is data
          fl_next_nxt = P_IDLE;
          st_nxt      = P_FLUSH;
        end
      end
      P_CMD: begin
        // whole run is swallowed, never reaching the radio
        if (take) begin
          if (quiet_r > join_thr) broken_nxt = 1'b1;
          if (len_r == `SCI_BODY_MAX) ovf_nxt = 1'b1;
          else begin
            body_nxt[len_r] = rx_byte;
            len_nxt         = len_r + 3'h1;
          end
        end else if (gap_hit) begin
          exec   = !broken_r && !ovf_r;
          st_nxt = P_IDLE;
        end
      end
      P_FLUSH: begin
        if (!pend_nxt) begin
          pend_nxt  = 1'b1;
          pbyte_nxt = held_r;
          st_nxt    = fl_next_r;
        end
      end
      default: st_nxt = P_IDLE;
    endcase
    ready_nxt = !pend_nxt && st_nxt != P_FLUSH;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r      <= P_IDLE;
      fl_next_r <= P_IDLE;
      held_r    <= 8'h00;
      pend_r    <= 1'b0;
      pbyte_r   <= 8'h00;
      ready_r   <= 1'b0;
      abort_r   <= 1'b0;
      body_r    <= '{default: 8'h00};
      len_r     <= 3'h0;
      ovf_r     <= 1'b0;
      broken_r  <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      fl_next_r <= fl_next_nxt;
      held_r    <= held_nxt;
      pend_r    <= pend_nxt;
      pbyte_r   <= pbyte_nxt;
      ready_r   <= ready_nxt;
      abort_r   <= abort_nxt;
      body_r    <= body_nxt;
      len_r     <= len_nxt;
      ovf_r     <= ovf_nxt;
      broken_r  <= broken_nxt;
    end
  end

  assign fin.valid = pend_r;
  assign fin.data  = pbyte_r;
  assign rx_ready  = ready_r;
  assign rx_abort  = abort_r;

  // command decode and settings
  send_t      ss_r;
  send_t      ss_nxt;
  reply_t     kind_r;
  reply_t     kind_nxt;
  logic       ext_r;
  logic       ext_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  tmode_t     tm_r;
  tmode_t     tm_nxt;
  logic       load_r;
  logic       save_r;
  logic       save_nxt;
  tmode_t     sdat_r;
  tmode_t     sdat_nxt;
  logic       txv_r;
  logic       txv_nxt;
  logic [7:0] txb_r;
  logic [7:0] txb_nxt;
  logic [8:0] rep;
  logic       is_save;
  logic       is_tq;
  logic       is_tset;
  logic [7:0] digit;

  assign digit   = body_r[3] - `SCI_CH_ZERO;
  assign is_save = body_r[0] == `SCI_CH_STAR && body_r[1] == `SCI_CH_STAR &&
                   body_r[2] == `SCI_CH_GT && term_at(body_r, len_r, 3'h3);
  assign is_tq   = body_r[0] == `SCI_CH_PCT && body_r[1] == `SCI_CH_T &&
                   body_r[2] == `SCI_CH_QM && term_at(body_r, len_r, 3'h3);
  assign is_tset = body_r[0] == `SCI_CH_PCT && body_r[1] == `SCI_CH_T &&
                   body_r[2] == `SCI_CH_EQ && term_at(body_r, len_r, 3'h4);

  // reply byte at index i: {last, byte}
  function automatic logic [8:0] reply_at(input reply_t k, input logic x,
                                          input tmode_t v,
                                          input logic [3:0] i);
    logic [7:0] t [5];
    logic [3:0] n;
    logic [8:0] r;
    t = '{default: 8'h00};
    n = 4'h1;
    unique case (k)
      R_OK: begin
        t[0] = `SCI_CH_O;
        t[1] = `SCI_CH_K;
        n    = 4'h2;
      end
      R_ERR: begin
        t = '{`SCI_CH_E, `SCI_CH_R, `SCI_CH_R, `SCI_CH_O, `SCI_CH_R};
        n = 4'h5;
      end
      default: begin
        if (x) begin
          t[0] = `SCI_CH_S;
          t[1] = `SCI_CH_L;
          t[2] = `SCI_CH_COLON;
          t[3] = `SCI_CH_ZERO + {6'h00, v};
          n    = 4'h4;
        end else t[0] = `SCI_CH_ZERO + {6'h00, v};
      end
    endcase
    // frame around the text
    if (i == 4'h0) r = {1'b0, `SCI_CH_STX};
    else if (i == 4'h1) r = {1'b0, `SCI_CH_S};
    else if (i == 4'h2) r = {1'b0, `SCI_CH_L};
    else if (i < n + 4'h3) r = {1'b0, t[3'(i - 4'h3)]};
    else if (i == n + 4'h3) r = {1'b0, `SCI_CH_ETX};
    else if (i == n + 4'h4) r = {1'b0, `SCI_CH_CR};
    else r = {1'b1, `SCI_CH_LF};
    return r;
  endfunction

  assign rep = reply_at(kind_r, ext_r, tm_r, idx_r);

  always_comb begin
    ss_nxt   = ss_r;
    kind_nxt = kind_r;
    ext_nxt  = ext_r;
    idx_nxt  = idx_r;
    tm_nxt   = tm_r;
    save_nxt = 1'b0;
    sdat_nxt = sdat_r;
    txv_nxt  = txv_r;
    txb_nxt  = txb_r;
    if (load_r) tm_nxt = nv_test_mode;
    unique case (ss_r)
      S_QUIET: begin
        // commands arriving mid-reply are dropped
        if (exec && (is_save || is_tq || is_tset)) begin
          ss_nxt  = S_SEND;
          idx_nxt = 4'h0;
          ext_nxt = ext_syntax;
          if (is_save) begin
            kind_nxt = R_OK;
            save_nxt = 1'b1;
            sdat_nxt = tm_r;
          end else if (is_tq) begin
            kind_nxt = R_VAL;
          end else if (digit <= 8'(`SCI_TMODE_MAX)) begin
            kind_nxt = R_OK;
            tm_nxt   = digit[1:0];
          end else begin
            kind_nxt = R_ERR;
          end
        end
      end
      S_SEND: begin
        if (!txv_r || tx_ready) begin
          txv_nxt = 1'b1;
          txb_nxt = rep[7:0];
          idx_nxt = idx_r + 4'h1;
          if (rep[8]) ss_nxt = S_QUIET;
        end
      end
    endcase
    if (ss_r == S_QUIET && txv_r && tx_ready) txv_nxt = 1'b0;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ss_r   <= S_QUIET;
      kind_r <= R_OK;
      ext_r  <= 1'b0;
      idx_r  <= 4'h0;
      tm_r   <= `SCI_TMODE_RST;
      load_r <= 1'b1;
      save_r <= 1'b0;
      sdat_r <= `SCI_TMODE_RST;
      txv_r  <= 1'b0;
      txb_r  <= 8'h00;
    end else begin
      ss_r   <= ss_nxt;
      kind_r <= kind_nxt;
      ext_r  <= ext_nxt;
      idx_r  <= idx_nxt;
      tm_r   <= tm_nxt;
      load_r <= 1'b0;
      save_r <= save_nxt;
      sdat_r <= sdat_nxt;
      txv_r  <= txv_nxt;
      txb_r  <= txb_nxt;
    end
  end

  assign tx_valid  = txv_r;
  assign tx_byte   = txb_r;
  assign test_mode = tm_r;
  assign save_req  = save_r;
  assign save_data = sdat_r;

  // registered output stage toward the radio
  logic       rv_r;
  logic       rv_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;

  assign fout.ready = !rv_r || radio_ready;

  always_comb begin
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    if (fout.ready) begin
      rv_nxt = fout.valid;
      if (fout.valid) rd_nxt = fout.data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rv_r <= 1'b0;
      rd_r <= 8'h00;
    end else begin
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign radio_valid = rv_r;
  assign radio_data  = rd_r;
endmodule

// ===== pkg/byte_stream_if.sv
// valid/ready byte stream between the interpreter and its fifo
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== pkg/sci_consts.svh
// constants of the serial command interpreter: characters, counts, sizes
// assumes a byte-wide receive stream and a character time given in cycles
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

`define SCI_CH_STX    8'h02
`define SCI_CH_ETX    8'h03
`define SCI_CH_CR     8'h0d
`define SCI_CH_LF     8'h0a
`define SCI_CH_S      8'h53
`define SCI_CH_L      8'h4c
`define SCI_CH_COLON  8'h3a
`define SCI_CH_STAR   8'h2a
`define SCI_CH_GT     8'h3e
`define SCI_CH_PCT    8'h25
`define SCI_CH_T      8'h54
`define SCI_CH_QM     8'h3f
`define SCI_CH_EQ     8'h3d
`define SCI_CH_ZERO   8'h30
`define SCI_CH_O      8'h4f
`define SCI_CH_K      8'h4b
`define SCI_CH_E      8'h45
`define SCI_CH_R      8'h52

`define SCI_GAP_CHARS   18'h00003
`define SCI_JOIN_CHARS  18'h00002
`define SCI_BODY_MAX    3'h6
`define SCI_TMODE_MAX   2'h2
`define SCI_TMODE_RST   2'h0
`define SCI_FIFO_WIDTH  8
`define SCI_FIFO_DEPTH  16

`endif

// ===== pkg/sci_pkg.sv
// types of the serial command interpreter
// assumes sci_consts.svh for the numeric constants
package sci_pkg;
  typedef logic [1:0] tmode_t;
  typedef enum logic [2:0] {
    P_IDLE  = 3'b000,
    P_DATA  = 3'b001,
    P_GOT_S = 3'b010,
    P_CMD   = 3'b011,
    P_FLUSH = 3'b100
  } parse_t;
  typedef enum logic [1:0] {
    R_OK  = 2'b00,
    R_ERR = 2'b01,
    R_VAL = 2'b10
  } reply_t;
  typedef enum logic {
    S_QUIET = 1'b0,
    S_SEND  = 1'b1
  } send_t;
endpackage
